// ---- pkg/i2c_master_pkg.sv ----
// Shared types and constants for the two-wire master receive, acknowledge and Stop block.
// Notes on behaviour
// - Buffer write during busy sequence sets collision flag.
// - Receive eight bits, then set interrupt and full.
// - Acknowledge pulls clock low, drives ack data.
// - Acknowledge: low one period, high one period.
// - Acknowledge end clears enable, stops counter, idles.
// - Stop drives data low, then counts period.
// - Stop releases clock, then data one period later.
// - Stop seen sets flag; period later interrupt.
// - Reset disables module and ends any transfer.
// - Start and Stop seen bits clear when disabled.
// - Busy bus with interrupt enabled: Stop interrupts.
// - Released data read low sets collision, idles.
// - Arbitration checked in transfers, starts, acknowledge.
// - Transmit collision halts, clears full, releases lines.
// - Condition collision aborts, releases, clears its enable.
// - After collision, a seen Stop sets interrupt.
// - Next buffer write restarts at first bit.
// - Start with low line aborts with collision.
// - Start: early data low restarts count; then clock low.
// - Each period is reload value counted to zero.
// - Receive request ignored unless module is idle.
package i2c_master_pkg;

  // Sequencer states.
  typedef enum logic [3:0] {
    st_idle = 4'h0,
    st_start_a = 4'h1,
    st_start_b = 4'h2,
    st_tx_low = 4'h3,
    st_tx_high = 4'h4,
    st_rx_low = 4'h5,
    st_rx_high = 4'h6,
    st_ack_low = 4'h7,
    st_ack_high = 4'h8,
    st_stop_a = 4'h9,
    st_stop_b = 4'hA,
    st_stop_c = 4'hB
  } mstate_e;

  // Sampled levels of the two bus lines.
  typedef struct packed {
    logic scl;
    logic sda;
  } lines_s;

  // Index of the last data bit of a byte, counted from zero.
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  // Index of the acknowledge bit slot in a transmitted byte.
  localparam logic [3:0] ACK_SLOT_BIT = 4'h8;
  // Value of the bit counter at the start of every byte.
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  // Value of the shift register and buffer after reset.
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Level of both lines assumed after reset: released and high.
  localparam lines_s LINES_RST = '{scl: 1'b1, sda: 1'b1};

endpackage

// ---- verilog/pin_sync.sv ----
// Three-stage synchroniser with agreement filter for the bus line inputs.
`timescale 1ns/10ps

module pin_sync #(
  parameter int W = 2
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Raw pin levels and the filtered result.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out
);

  // Stage one is read only by stage two, to keep metastability contained.
  logic [W-1:0] meta_reg;
  // Stages two and three, compared to accept a change.
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  // Accepted level.
  logic [W-1:0] level_reg;

  // Each bit takes a new level only once stages two and three agree.
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          meta_reg[gi] <= 1'b1;
          s2_reg[gi] <= 1'b1;
          s3_reg[gi] <= 1'b1;
          level_reg[gi] <= 1'b1;
        end else begin
          meta_reg[gi] <= async_in[gi];
          s2_reg[gi] <= meta_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            level_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // The filtered level drives the consumer.
  assign level_out = level_reg;

endmodule

// ---- verilog/i2c_master_core.sv ----
// Two-wire master sequencer: Start, byte send and receive, acknowledge, Stop and arbitration.
`timescale 1ns/10ps

module i2c_master_core #(
  parameter int BAUD_W = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Module control.
  input wire logic module_enable,
  input wire logic [BAUD_W-1:0] baud_reload_value,
  input wire logic stop_irq_enable,
  // Sequence requests, one-cycle set pulses, and the acknowledge level.
  input wire logic start_set,
  input wire logic receive_set,
  input wire logic ack_set,
  input wire logic stop_set,
  input wire logic ack_data_bit,
  // Shared buffer access.
  input wire logic buf_wr,
  input wire logic [7:0] buf_wdata,
  input wire logic buf_rd,
  output logic [7:0] rx_tx_buffer,
  // Flag clears from software, one-cycle pulses.
  input wire logic sif_clear,
  input wire logic write_collision_flag_clear,
  input wire logic bcl_clear,
  // Control and status bits.
  output logic start_enable,
  output logic receive_enable,
  output logic ack_sequence_enable,
  output logic stop_sequence_enable,
  output logic ack_status_bit,
  output logic buffer_full_flag,
  output logic write_collision_flag,
  output logic serial_interrupt_flag,
  output logic bus_collision_flag,
  output logic start_detected,
  output logic stop_detected,
  // Open-drain bus lines.
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  // Sequencer state and its next value.
  i2c_master_pkg::mstate_e state_reg;
  i2c_master_pkg::mstate_e state_next;
  // Filtered line levels and their values one cycle earlier.
  i2c_master_pkg::lines_s line;
  i2c_master_pkg::lines_s line_prev_reg;
  // Baud counter.
  logic [BAUD_W-1:0] cnt_reg;
  // Bit counter and serial shift register.
  logic [3:0] bit_cnt_reg;
  logic [7:0] serial_shift_register;
  // Control enables.
  logic start_en_reg;
  logic rcv_en_reg;
  logic ack_en_reg;
  logic stop_en_reg;
  // Status flags.
  logic sif_reg;
  logic write_collision_flag_reg;
  logic bcl_reg;
  logic bf_reg;
  logic ack_status_bit_reg;
  logic start_det_reg;
  logic stop_det_reg;
  logic [7:0] buf_reg;
  // Lines held low between sequences while the master owns the bus.
  logic scl_hold_reg;
  logic sda_hold_reg;
  // Combinational events from the sequencer.
  logic wait_hold;
  logic coll;
  logic fin_start;
  logic fin_tx;
  logic fin_rx;
  logic fin_ack;
  logic fin_stop;
  logic tx_bit_end;
  logic rx_sample;

  // Filter the raw pins into the clock domain.
  pin_sync #(
    .W(2)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({scl_in, sda_in}),
    .level_out(line)
  );

  // Decoded conditions.
  wire is_idle = (state_reg == i2c_master_pkg::st_idle);
  wire cnt_zero = (cnt_reg == '0);
  wire tick = cnt_zero & ~wait_hold;
  wire tx_bit = (bit_cnt_reg > i2c_master_pkg::LAST_DATA_BIT) | serial_shift_register[7];
  wire start_evt = line_prev_reg.scl & line.scl & line_prev_reg.sda & ~line.sda;
  wire stop_evt = line_prev_reg.scl & line.scl & ~line_prev_reg.sda & line.sda;
  wire go_ok = is_idle & module_enable;
  // A Start with either line already low is refused as a collision.
  wire start_bad = go_ok & start_set & ~(line.scl & line.sda);
  wire start_go = go_ok & start_set & ~start_bad;
  wire wr_ok = buf_wr & go_ok;
  // A write while any sequence runs is refused and flagged.
  wire wr_refused = buf_wr & ~go_ok;
  wire high_phase = (state_reg == i2c_master_pkg::st_tx_high) |
    (state_reg == i2c_master_pkg::st_ack_high);
  wire last_rx = (bit_cnt_reg == i2c_master_pkg::LAST_DATA_BIT);
  wire last_tx = (bit_cnt_reg == i2c_master_pkg::ACK_SLOT_BIT);

  // Line drive decode: the master only ever pulls a line low or lets it go.
  wire scl_drive = (is_idle & scl_hold_reg) |
    (state_reg == i2c_master_pkg::st_tx_low) |
    (state_reg == i2c_master_pkg::st_rx_low) |
    (state_reg == i2c_master_pkg::st_ack_low) |
    (state_reg == i2c_master_pkg::st_stop_a);
  wire sda_drive = (is_idle & sda_hold_reg) |
    (state_reg == i2c_master_pkg::st_start_b) |
    (state_reg == i2c_master_pkg::st_stop_a) |
    (state_reg == i2c_master_pkg::st_stop_b) |
    (((state_reg == i2c_master_pkg::st_tx_low) | (state_reg == i2c_master_pkg::st_tx_high)) &
      ~tx_bit) |
    (((state_reg == i2c_master_pkg::st_ack_low) | (state_reg == i2c_master_pkg::st_ack_high)) &
      ~ack_data_bit);
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_drive;
  assign sda_oe = sda_drive;

  // A released data line read low while the clock is high means lost arbitration.
  // The acknowledge slot of a sent byte belongs to the slave and is not checked.
  wire arb_lost = high_phase & line.scl & ~sda_drive & ~line.sda &
    ~((state_reg == i2c_master_pkg::st_tx_high) & last_tx);

  // Next-state logic and sequencer events.
  always_comb begin
    state_next = state_reg;
    wait_hold = 1'b0;
    coll = 1'b0;
    fin_start = 1'b0;
    fin_tx = 1'b0;
    fin_rx = 1'b0;
    fin_ack = 1'b0;
    fin_stop = 1'b0;
    tx_bit_end = 1'b0;
    rx_sample = 1'b0;
    case (state_reg)
      // Idle: accept one request at a time.
      i2c_master_pkg::st_idle: begin
        if (start_go) begin
          state_next = i2c_master_pkg::st_start_a;
        end else if (wr_ok) begin
          state_next = i2c_master_pkg::st_tx_low;
        end else if (go_ok & receive_set) begin
          state_next = i2c_master_pkg::st_rx_low;
        end else if (go_ok & ack_set) begin
          state_next = i2c_master_pkg::st_ack_low;
        end else if (go_ok & stop_set) begin
          state_next = i2c_master_pkg::st_stop_a;
        end
      end
      // Start, first count with both lines released.
      i2c_master_pkg::st_start_a: begin
        if (~line.scl & line.sda) begin
          coll = 1'b1;
        end else if (~line.sda | tick) begin
          // Data pulled low early by another master restarts the count at once.
          state_next = i2c_master_pkg::st_start_b;
        end
      end
      // Start, second count with data low; a low clock here is no collision.
      i2c_master_pkg::st_start_b: begin
        if (tick) begin
          fin_start = 1'b1;
        end
      end
      // Clock low: data bit is placed.
      i2c_master_pkg::st_tx_low: begin
        if (tick) begin
          state_next = i2c_master_pkg::st_tx_high;
        end
      end
      // Clock released: count starts only once the clock is seen high.
      i2c_master_pkg::st_tx_high: begin
        wait_hold = ~line.scl;
        if (arb_lost) begin
          coll = 1'b1;
        end else if (tick) begin
          tx_bit_end = 1'b1;
          if (last_tx) begin
            fin_tx = 1'b1;
          end else begin
            state_next = i2c_master_pkg::st_tx_low;
          end
        end
      end
      // Receive, clock low.
      i2c_master_pkg::st_rx_low: begin
        if (tick) begin
          state_next = i2c_master_pkg::st_rx_high;
        end
      end
      // Receive, clock high: data sampled at the end of the period.
      i2c_master_pkg::st_rx_high: begin
        wait_hold = ~line.scl;
        if (tick) begin
          rx_sample = 1'b1;
          if (last_rx) begin
            fin_rx = 1'b1;
          end else begin
            state_next = i2c_master_pkg::st_rx_low;
          end
        end
      end
      // Acknowledge, clock held low for one period.
      i2c_master_pkg::st_ack_low: begin
        if (tick) begin
          state_next = i2c_master_pkg::st_ack_high;
        end
      end
      // Acknowledge, clock high for one period after it is seen high.
      i2c_master_pkg::st_ack_high: begin
        wait_hold = ~line.scl;
        if (arb_lost) begin
          coll = 1'b1;
        end else if (tick) begin
          fin_ack = 1'b1;
        end
      end
      // Stop, data pulled low; count once data is seen low.
      i2c_master_pkg::st_stop_a: begin
        wait_hold = line.sda;
        if (tick) begin
          state_next = i2c_master_pkg::st_stop_b;
        end
      end
      // Stop, clock released; one period after it is seen high.
      i2c_master_pkg::st_stop_b: begin
        wait_hold = ~line.scl;
        if (tick) begin
          state_next = i2c_master_pkg::st_stop_c;
        end
      end
      // Stop, data released; one period after the Stop is seen.
      i2c_master_pkg::st_stop_c: begin
        wait_hold = ~(line.sda & line.scl);
        if (tick) begin
          fin_stop = 1'b1;
        end
      end
      default: begin
        state_next = i2c_master_pkg::st_idle;
      end
    endcase
    // Any finish or collision, or a disabled module, returns to idle.
    if (coll | fin_start | fin_tx | fin_rx | fin_ack | fin_stop | ~module_enable) begin
      state_next = i2c_master_pkg::st_idle;
    end
  end

  // Sequencer state register.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= i2c_master_pkg::st_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  // Baud counter: loaded on every state change or wait, else counts down to zero.
  // It stands still in idle, so the master clock is suspended between sequences.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if ((state_next != state_reg) | wait_hold) begin
      cnt_reg <= baud_reload_value;
    end else if (~cnt_zero & ~is_idle) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Bit counter and shift register; each byte begins at its first bit.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bit_cnt_reg <= i2c_master_pkg::BIT_CNT_RST;
      serial_shift_register <= i2c_master_pkg::BYTE_RST;
    end else if (is_idle) begin
      bit_cnt_reg <= i2c_master_pkg::BIT_CNT_RST;
      if (wr_ok) begin
        serial_shift_register <= buf_wdata;
      end
    end else if (tx_bit_end) begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      serial_shift_register <= {serial_shift_register[6:0], 1'b0};
    end else if (rx_sample) begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      serial_shift_register <= {serial_shift_register[6:0], line.sda};
    end
  end

  // Control enables: set from idle only, cleared by hardware on finish or collision.
  always_ff @(posedge ref_clk) begin
    if (rst | ~module_enable) begin
      start_en_reg <= 1'b0;
      rcv_en_reg <= 1'b0;
      ack_en_reg <= 1'b0;
      stop_en_reg <= 1'b0;
    end else begin
      start_en_reg <= start_go | (start_en_reg & ~fin_start & ~coll);
      rcv_en_reg <= (go_ok & receive_set & ~start_set & ~buf_wr) |
        (rcv_en_reg & ~fin_rx & ~coll);
      ack_en_reg <= (state_next == i2c_master_pkg::st_ack_low & is_idle) |
        (ack_en_reg & ~fin_ack & ~coll);
      stop_en_reg <= (state_next == i2c_master_pkg::st_stop_a & is_idle) |
        (stop_en_reg & ~fin_stop & ~coll);
    end
  end

  // Line hold after a sequence: clock stays low until a Stop or collision.
  always_ff @(posedge ref_clk) begin
    if (rst | ~module_enable) begin
      scl_hold_reg <= 1'b0;
      sda_hold_reg <= 1'b0;
    end else if (coll | fin_stop) begin
      scl_hold_reg <= 1'b0;
      sda_hold_reg <= 1'b0;
    end else if (fin_start) begin
      scl_hold_reg <= 1'b1;
      sda_hold_reg <= 1'b1;
    end else if (fin_tx | fin_rx | fin_ack) begin
      scl_hold_reg <= 1'b1;
      sda_hold_reg <= 1'b0;
    end
  end

  // Buffer, full flag and acknowledge status.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      buf_reg <= i2c_master_pkg::BYTE_RST;
      bf_reg <= 1'b0;
      ack_status_bit_reg <= 1'b0;
    end else begin
      if (wr_ok) begin
        buf_reg <= buf_wdata;
      end else if (fin_rx) begin
        buf_reg <= {serial_shift_register[6:0], line.sda};
      end
      // Setting wins over the clear by a read in the same cycle.
      if (wr_ok | fin_rx) begin
        bf_reg <= 1'b1;
      end else if (buf_rd | (coll & (state_reg == i2c_master_pkg::st_tx_high)) |
          (tx_bit_end & (bit_cnt_reg == i2c_master_pkg::LAST_DATA_BIT))) begin
        bf_reg <= 1'b0;
      end
      if (fin_tx) begin
        ack_status_bit_reg <= line.sda;
      end
    end
  end

  // Sticky flags: hardware set wins over the software clear.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sif_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      bcl_reg <= 1'b0;
    end else begin
      // Interrupt on finish, or on a Stop seen while busy with the Stop interrupt on, or after a lost bus.
      sif_reg <= fin_start | fin_tx | fin_rx | fin_ack | fin_stop |
        (stop_evt & ~stop_en_reg & ((start_det_reg & stop_irq_enable) | bcl_reg)) |
        (sif_reg & ~sif_clear);
      write_collision_flag_reg <= wr_refused | (write_collision_flag_reg & ~write_collision_flag_clear);
      bcl_reg <= coll | start_bad | (bcl_reg & ~bcl_clear);
    end
  end

  // Bus monitor: Start and Stop seen bits, cleared when disabled.
  always_ff @(posedge ref_clk) begin
    if (rst | ~module_enable) begin
      start_det_reg <= 1'b0;
      stop_det_reg <= 1'b0;
      line_prev_reg <= i2c_master_pkg::LINES_RST;
    end else begin
      line_prev_reg <= line;
      if (start_evt) begin
        start_det_reg <= 1'b1;
        stop_det_reg <= 1'b0;
      end else if (stop_evt) begin
        start_det_reg <= 1'b0;
        stop_det_reg <= 1'b1;
      end
    end
  end

  // Status outputs straight from their registers.
  assign rx_tx_buffer = buf_reg;
  assign start_enable = start_en_reg;
  assign receive_enable = rcv_en_reg;
  assign ack_sequence_enable = ack_en_reg;
  assign stop_sequence_enable = stop_en_reg;
  assign ack_status_bit = ack_status_bit_reg;
  assign buffer_full_flag = bf_reg;
  assign write_collision_flag = write_collision_flag_reg;
  assign serial_interrupt_flag = sif_reg;
  assign bus_collision_flag = bcl_reg;
  assign start_detected = start_det_reg;
  assign stop_detected = stop_det_reg;

  // Checks on the sequencer.
  chk_write_collision_flag_keeps_buf: assert property (@(posedge ref_clk) disable iff (rst)
    wr_refused |=> write_collision_flag && rx_tx_buffer == $past(rx_tx_buffer))
    else $error("refused write changed buffer or missed flag");

  chk_rx_done_flags: assert property (@(posedge ref_clk) disable iff (rst)
    fin_rx |=> serial_interrupt_flag && buffer_full_flag && !receive_enable && scl_oe)
    else $error("receive end flags wrong");

  chk_ack_low_drive: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == i2c_master_pkg::st_ack_low |-> scl_oe && (sda_oe == !ack_data_bit))
    else $error("acknowledge drive wrong");

  chk_ack_end_idle: assert property (@(posedge ref_clk) disable iff (rst)
    fin_ack |=> (is_idle && !ack_sequence_enable) ##1 $stable(cnt_reg))
    else $error("acknowledge did not end cleanly");

  chk_stop_sda_low: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == i2c_master_pkg::st_stop_a && line.sda |=> cnt_reg == baud_reload_value)
    else $error("stop count not held while data high");

  chk_stop_finish: assert property (@(posedge ref_clk) disable iff (rst)
    fin_stop |=> serial_interrupt_flag && !stop_sequence_enable && !scl_oe && !sda_oe)
    else $error("stop end flags wrong");

  chk_coll_release: assert property (@(posedge ref_clk) disable iff (rst)
    coll |=> bus_collision_flag && is_idle && !scl_oe && !sda_oe && !start_enable)
    else $error("collision did not release bus");

  chk_disable_clear: assert property (@(posedge ref_clk) disable iff (rst)
    !module_enable |=> !start_detected && !stop_detected && is_idle)
    else $error("disable left state behind");

  chk_rcv_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    receive_set && !is_idle && !receive_enable |=> !receive_enable)
    else $error("receive accepted while busy");

  chk_busy_stop_irq: assert property (@(posedge ref_clk) disable iff (rst)
    stop_evt && start_detected && stop_irq_enable && module_enable && !stop_sequence_enable
      |=> serial_interrupt_flag)
    else $error("stop on busy bus gave no interrupt");

endmodule

// ---- dv/i2c_slave_model.sv ----
// Behavioural far-side party: a slave that sends one byte and a rival that holds data low.
`timescale 1ns/10ps

module i2c_slave_model (
  // Observed bus clock level.
  input wire logic scl,
  // Control from the bench.
  input wire logic send,
  input wire logic grab,
  input wire logic [7:0] tx_byte,
  // High while this party pulls the data line low.
  output logic pull
);
  // Count of clock falls seen since sending began.
  int idx;

  // Step to the next bit on each clock fall, so data changes only while the clock is low.
  always @(negedge scl or negedge send) begin
    if (!send) begin
      idx <= 0;
    end else begin
      idx <= idx + 1;
    end
  end

  // Pull low for a zero bit, MSB first, then release after eight bits; grab wins always.
  assign pull = grab | (send && idx < 8 && !tx_byte[3'(7 - idx)]);
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the two-wire master receive, acknowledge, Stop and arbitration block.
`timescale 1ns/10ps

module tb_top;
  logic ref_clk, rst, module_enable, ack_data_bit, buf_wr, buf_rd, scl_hold, send, grab;
  logic [3:0] set_v;
  logic [2:0] clr_v;
  logic [7:0] buf_wdata, rx_tx_buffer, tx_byte;
  logic start_enable, receive_enable, ack_sequence_enable, stop_sequence_enable;
  logic buffer_full_flag, write_collision_flag, serial_interrupt_flag, bus_collision_flag;
  logic start_detected, stop_detected, scl_oe, sda_oe, pull;
  logic stop_irq_enable, ack_status_bit;
  // Wired-AND bus levels with pull-ups.
  wire logic scl_w = ~(scl_oe | scl_hold);
  wire logic sda_w = ~(sda_oe | pull);
  int n_fail, comparisons, cyc;
  // Received byte beside the acknowledge level to send back.
  typedef struct packed {logic [7:0] rx; logic nack;} row_s;
  row_s rows [3] = '{'{8'hA5, 1'b0}, '{8'h5A, 1'b1}, '{8'h01, 1'b0}};

  i2c_master_core dut (.ref_clk(ref_clk), .rst(rst), .module_enable(module_enable),
    .baud_reload_value(8'h03), .stop_irq_enable(stop_irq_enable), .start_set(set_v[0]),
    .receive_set(set_v[1]), .ack_set(set_v[2]), .stop_set(set_v[3]),
    .ack_data_bit(ack_data_bit), .buf_wr(buf_wr), .buf_wdata(buf_wdata), .buf_rd(buf_rd),
    .rx_tx_buffer(rx_tx_buffer), .sif_clear(clr_v[0]), .write_collision_flag_clear(clr_v[1]),
    .bcl_clear(clr_v[2]), .start_enable(start_enable), .receive_enable(receive_enable),
    .ack_sequence_enable(ack_sequence_enable), .stop_sequence_enable(stop_sequence_enable),
    .ack_status_bit(ack_status_bit), .buffer_full_flag(buffer_full_flag),
    .write_collision_flag(write_collision_flag), .serial_interrupt_flag(serial_interrupt_flag),
    .bus_collision_flag(bus_collision_flag), .start_detected(start_detected),
    .stop_detected(stop_detected), .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe));

  i2c_slave_model peer (.scl(scl_w), .send(send), .grab(grab), .tx_byte(tx_byte), .pull(pull));

  // Clock of 10 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Compares a seen value with the expected one and counts both outcomes.
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle pulse on the sequence requests.
  task go(input logic [3:0] v);
    @(posedge ref_clk) set_v <= v;
    @(posedge ref_clk) set_v <= 4'h0;
    #1;
  endtask

  // One-cycle pulse on the flag clears.
  task clr(input logic [2:0] v);
    @(posedge ref_clk) clr_v <= v;
    @(posedge ref_clk) clr_v <= 3'h0;
    #1;
  endtask

  // Buffer write pulse, or read pulse when wr is low.
  task wbuf(input logic wr, input logic [7:0] d);
    @(posedge ref_clk) begin
      buf_wr <= wr;
      buf_rd <= !wr;
      buf_wdata <= d;
    end
    @(posedge ref_clk) {buf_wr, buf_rd} <= 2'h0;
    #1;
  endtask

  // Waits, bounded, for the interrupt flag, checks it and clears it.
  task wsif;
    repeat (3000) if (serial_interrupt_flag !== 1'b1) @(posedge ref_clk);
    chk(serial_interrupt_flag, 8'h01);
    clr(3'h1);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task results;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  // Main sequence: reset, the table of receive rows, then the awkward cases.
  initial begin
    {rst, module_enable, stop_irq_enable, ack_data_bit} = 4'hE;
    {buf_wr, buf_rd, scl_hold, send, grab} = 5'h00;
    {set_v, clr_v, buf_wdata, tx_byte} = 23'h0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk) #1;
    chk({buffer_full_flag, serial_interrupt_flag, scl_oe, sda_oe, start_enable}, 8'h00);
    repeat (6) @(posedge ref_clk);
    foreach (rows[i]) begin
      go(4'h1);
      wsif();
      wbuf(1'b1, 8'h91);
      wsif();
      chk(ack_status_bit, 8'h01);
      tx_byte <= rows[i].rx;
      send <= 1'b1;
      go(4'h2);
      repeat (5) @(posedge ref_clk);
      wbuf(1'b1, 8'h3C);
      wsif();
      send <= 1'b0;
      chk(rx_tx_buffer, rows[i].rx);
      chk({write_collision_flag, buffer_full_flag}, 8'h03);
      clr(3'h2);
      wbuf(1'b0, 8'h00);
      chk(buffer_full_flag, 8'h00);
      ack_data_bit <= rows[i].nack;
      go(4'h4);
      go(4'h2);
      chk({receive_enable, scl_oe, sda_oe}, {6'h00, 1'b1, ~rows[i].nack});
      wsif();
      chk(ack_sequence_enable, 8'h00);
      go(4'h8);
      wsif();
      chk({stop_detected, stop_sequence_enable, scl_oe, sda_oe}, 8'h08);
    end
    go(4'h1);
    wsif();
    grab <= 1'b1;
    wbuf(1'b1, 8'hFF);
    repeat (200) if (bus_collision_flag !== 1'b1) @(posedge ref_clk);
    chk(bus_collision_flag, 8'h01);
    chk({buffer_full_flag, scl_oe, sda_oe}, 8'h00);
    clr(3'h1);
    grab <= 1'b0;
    repeat (20) @(posedge ref_clk) #1;
    chk(serial_interrupt_flag, 8'h01);
    clr(3'h5);
    // Another master's Start and Stop: interrupt only when the Stop interrupt is on.
    stop_irq_enable <= 1'b0;
    repeat (2) begin
      grab <= 1'b1;
      repeat (10) @(posedge ref_clk);
      grab <= 1'b0;
      repeat (10) @(posedge ref_clk) #1;
      chk(serial_interrupt_flag, {7'h00, stop_irq_enable});
      stop_irq_enable <= 1'b1;
    end
    clr(3'h1);
    scl_hold <= 1'b1;
    repeat (6) @(posedge ref_clk);
    go(4'h1);
    repeat (4) @(posedge ref_clk) #1;
    chk({bus_collision_flag, start_enable}, 8'h02);
    scl_hold <= 1'b0;
    module_enable <= 1'b0;
    repeat (3) @(posedge ref_clk) #1;
    chk({stop_detected, start_detected}, 8'h00);
    results();
  end
endmodule
